// *** rtl/dcg_defines.svh ***
`ifndef DCG_DEFINES_SVH
`define DCG_DEFINES_SVH
// ************************************************************
// Register map
// ************************************************************
`define DCG_ADDR_REV 7'h00
`define DCG_ADDR_PART 7'h01
`define DCG_ADDR_SRST 7'h02
`define DCG_ADDR_SLEEP 7'h03
`define DCG_ADDR_A_BIAS 7'h04
`define DCG_ADDR_A_ATTEN 7'h05
`define DCG_ADDR_B_BIAS 7'h06
`define DCG_ADDR_B_ATTEN 7'h07
`define DCG_ADDR_LAST 7'h07
// Identification values are arbitrary
`define DCG_REV_CODE 8'h5A
`define DCG_PART_CODE 8'h3C
// ************************************************************
// Fields and defaults
// ************************************************************
`define DCG_BIT_CHAN_A 0
`define DCG_BIT_CHAN_B 4
`define DCG_ATTEN_MSB 5
`define DCG_ATTEN_RSVD 2'h0
`define DCG_BIAS_DEFAULT 8'h20
`define DCG_ATTEN_DEFAULT 6'h14
`define DCG_BIAS_TOP_STEP 4'h8
`define DCG_BIAS_DEFAULT_STEP 4'h6
// ************************************************************
// Serial frame
// ************************************************************
`define DCG_CNT_ADDR_DONE 4'h8
`define DCG_CNT_LAST 4'hF
`define DCG_CNT_WRAP 4'h0
`define DCG_DIR_POS 14
`endif

// *** rtl/dcg_pkg.sv ***
package dcg_pkg;
  typedef logic [7:0] dcg_byte_t;
  typedef logic [6:0] dcg_addr_t;
  typedef logic [5:0] dcg_atten_t;
  typedef logic [3:0] dcg_step_t;
  typedef enum logic {
    dcg_dir_write = 1'h0,
    dcg_dir_read = 1'h1
  } dcg_dir_t;
  typedef struct packed {
    dcg_byte_t srst;
    dcg_byte_t sleep;
    dcg_byte_t a_bias;
    dcg_byte_t a_atten;
    dcg_byte_t b_bias;
    dcg_byte_t b_atten;
  } dcg_mirror_t;
endpackage

// *** rtl/dcg_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface dcg_link_if;
  logic word_tgl;
  dcg_pkg::dcg_addr_t word_addr;
  dcg_pkg::dcg_byte_t word_data;
  dcg_pkg::dcg_mirror_t mirror;
  modport link (output word_tgl, output word_addr, output word_data, input mirror);
  modport core (input word_tgl, input word_addr, input word_data, output mirror);
endinterface
`default_nettype wire

// *** rtl/dcg_spi_link.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dcg_defines.svh"
module dcg_spi_link (
  input wire logic sclk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  dcg_link_if.link lnk
);
  logic frame_rst_n;
  logic [3:0] bit_cnt;
  logic [14:0] shreg;
  dcg_pkg::dcg_byte_t rd_shift;
  dcg_pkg::dcg_byte_t rd_byte;

  // Chip select high ends the frame; a partial word is dropped
  assign frame_rst_n = rst_n & ~cs_n;

  function automatic dcg_pkg::dcg_byte_t read_byte(input dcg_pkg::dcg_addr_t a, input dcg_pkg::dcg_mirror_t m);
    unique case (a)
      `DCG_ADDR_REV: read_byte = `DCG_REV_CODE;
      `DCG_ADDR_PART: read_byte = `DCG_PART_CODE;
      `DCG_ADDR_SRST: read_byte = m.srst;
      `DCG_ADDR_SLEEP: read_byte = m.sleep;
      `DCG_ADDR_A_BIAS: read_byte = m.a_bias;
      `DCG_ADDR_A_ATTEN: read_byte = m.a_atten;
      `DCG_ADDR_B_BIAS: read_byte = m.b_bias;
      `DCG_ADDR_B_ATTEN: read_byte = m.b_atten;
      default: read_byte = 8'h00;
    endcase
  endfunction

  assign rd_byte = read_byte(shreg[6:0], lnk.mirror);

  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt <= `DCG_CNT_WRAP;
      shreg <= 15'h0000;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
      shreg <= {shreg[13:0], sdi};
    end
  end

  // Held word survives chip select so the core can still fetch it
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      lnk.word_tgl <= 1'h0;
      lnk.word_addr <= 7'h00;
      lnk.word_data <= 8'h00;
    end else if (bit_cnt == `DCG_CNT_LAST && shreg[`DCG_DIR_POS] == dcg_pkg::dcg_dir_write) begin
      lnk.word_addr <= shreg[13:7];
      lnk.word_data <= {shreg[6:0], sdi};
      lnk.word_tgl <= ~lnk.word_tgl;
    end
  end

  // Read data goes out on falling edges so the host samples on rising ones
  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sdo <= 1'h0;
      sdo_oe <= 1'h0;
      rd_shift <= 8'h00;
    end else if (bit_cnt == `DCG_CNT_ADDR_DONE && shreg[7] == dcg_pkg::dcg_dir_read) begin
      rd_shift <= {rd_byte[6:0], 1'h0};
      sdo <= rd_byte[7];
      sdo_oe <= 1'h1;
    end else if (bit_cnt == `DCG_CNT_WRAP) begin
      sdo <= 1'h0;
      sdo_oe <= 1'h0;
    end else begin
      sdo <= rd_shift[7];
      rd_shift <= {rd_shift[6:0], 1'h0};
    end
  end

  a_rsvd_read_zero: assert property (@(negedge sclk) disable iff (!frame_rst_n)
    (bit_cnt == `DCG_CNT_ADDR_DONE && shreg[7] && shreg[6:0] > `DCG_ADDR_LAST) |=> (!sdo && sdo_oe) [*7])
    else $error("reserved address read returned a one");
  a_write_commit: assert property (@(posedge sclk) disable iff (!frame_rst_n)
    (bit_cnt == `DCG_CNT_LAST && !shreg[`DCG_DIR_POS]) |=> lnk.word_tgl != $past(lnk.word_tgl))
    else $error("sixteenth edge of a write did not commit");
endmodule
`default_nettype wire

// *** rtl/dcg_bias_step.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dcg_defines.svh"
module dcg_bias_step (
  input wire logic clock,
  input wire logic rst_n,
  input wire dcg_pkg::dcg_byte_t bias,
  output dcg_pkg::dcg_step_t step
);
  // Highest set bit picks one of nine power steps, zero is the lowest
  function automatic dcg_pkg::dcg_step_t top_bit_step(input dcg_pkg::dcg_byte_t b);
    top_bit_step = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        top_bit_step = 4'(i + 1);
      end
    end
  endfunction

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      step <= `DCG_BIAS_DEFAULT_STEP;
    end else begin
      step <= top_bit_step(bias);
    end
  end

  a_bias_top_step: assert property (@(posedge clock) disable iff (!rst_n)
    bias[7] |=> step == `DCG_BIAS_TOP_STEP)
    else $error("top bias bit did not select highest step");
endmodule
`default_nettype wire

// *** rtl/dcg_regs_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dcg_defines.svh"
// Functional notes
// - Soft reset bits 4 (B) and 0 (A) clear themselves; writing zero does nothing.
// - A channel soft reset restores only that channel's registers to defaults.
// - Address 3 holds sleep bits: bit 4 channel B, bit 0 channel A.
// - Address 4 channel A bias byte drives its output; reset restores default.
// - Address 5 channel A attenuator drives its output; reset restores default.
// - Address 6 channel B bias byte drives its output; reset restores default.
// - Address 7 channel B attenuator drives its output; reset restores default.
// - Bias byte read by highest set bit: nine steps, bit 7 highest.
// - Addresses 8 to 127 are read-only and read as zero.
// - Bias registers reset to 20 hex.
// - Attenuator registers reset to 14 hex.
// - Bits 7-5 and 3-1 of reset and sleep registers read zero.
// - Frames are 16 bits: address byte then data; writes commit on each sixteenth edge.
// - Sleep by pin or bit keeps all register contents.
// - Power-on reset forces every register to its default.
// - Attenuator uses six low bits in 1 dB steps; bits 7-6 read zero.
module dcg_regs_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  input wire logic sleep_pin,
  output logic chan_a_sleep,
  output logic chan_b_sleep,
  output dcg_pkg::dcg_byte_t chan_a_bias_out,
  output dcg_pkg::dcg_byte_t chan_a_atten_out,
  output dcg_pkg::dcg_byte_t chan_b_bias_out,
  output dcg_pkg::dcg_byte_t chan_b_atten_out,
  output dcg_pkg::dcg_step_t chan_a_bias_step,
  output dcg_pkg::dcg_step_t chan_b_bias_step
);
  // ************************************************************
  // Serial link in its own clock domain
  // ************************************************************
  dcg_link_if lnk ();

  dcg_spi_link u_link (
    .sclk(spi_sclk),
    .rst_n(rst_n),
    .cs_n(spi_cs_n),
    .sdi(spi_sdi),
    .sdo(spi_sdo),
    .sdo_oe(spi_sdo_oe),
    .lnk(lnk)
  );

  // ************************************************************
  // Crossing of committed words
  // ************************************************************
  logic tgl_meta;
  logic tgl_sync;
  logic tgl_seen;
  logic commit;

  // Address and data are held for a whole frame after the toggle, so they are
  // long settled when the synchronised toggle reaches this domain
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tgl_meta <= 1'h0;
      tgl_sync <= 1'h0;
      tgl_seen <= 1'h0;
    end else begin
      tgl_meta <= lnk.word_tgl;
      tgl_sync <= tgl_meta;
      tgl_seen <= tgl_sync;
    end
  end

  assign commit = tgl_sync ^ tgl_seen;

  // ************************************************************
  // Sleep pin synchroniser
  // ************************************************************
  logic pin_meta;
  logic pin_sync;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= 1'h0;
      pin_sync <= 1'h0;
    end else begin
      pin_meta <= sleep_pin;
      pin_sync <= pin_meta;
    end
  end

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic logic write_hit(input logic fire, input dcg_pkg::dcg_addr_t addr,
                                     input dcg_pkg::dcg_addr_t target);
    write_hit = fire && (addr == target);
  endfunction

  // Only the two channel bits exist; every other bit reads zero
  function automatic dcg_pkg::dcg_byte_t place_bits(input logic bit_a, input logic bit_b);
    place_bits = 8'h00;
    place_bits[`DCG_BIT_CHAN_A] = bit_a;
    place_bits[`DCG_BIT_CHAN_B] = bit_b;
  endfunction

  // ************************************************************
  // Per-channel register sets
  // ************************************************************
  logic chan_srst [2];
  logic sleep_bit [2];
  dcg_pkg::dcg_byte_t bias [2];
  dcg_pkg::dcg_atten_t atten [2];
  logic sleep_q [2];
  dcg_pkg::dcg_byte_t bias_q [2];
  dcg_pkg::dcg_byte_t atten_q [2];
  dcg_pkg::dcg_step_t step_q [2];

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    localparam int SelBit = (ch == 0) ? `DCG_BIT_CHAN_A : `DCG_BIT_CHAN_B;
    localparam dcg_pkg::dcg_addr_t BiasAddr = (ch == 0) ? `DCG_ADDR_A_BIAS : `DCG_ADDR_B_BIAS;
    localparam dcg_pkg::dcg_addr_t AttenAddr = (ch == 0) ? `DCG_ADDR_A_ATTEN : `DCG_ADDR_B_ATTEN;

    // Pulse lasts one cycle, so the bit reads back as zero afterwards
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        chan_srst[ch] <= 1'h0;
      end else begin
        chan_srst[ch] <= write_hit(commit, lnk.word_addr, `DCG_ADDR_SRST) && lnk.word_data[SelBit];
      end
    end

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        sleep_bit[ch] <= 1'h0;
      end else if (chan_srst[ch]) begin
        sleep_bit[ch] <= 1'h0;
      end else if (write_hit(commit, lnk.word_addr, `DCG_ADDR_SLEEP)) begin
        sleep_bit[ch] <= lnk.word_data[SelBit];
      end
    end

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        bias[ch] <= `DCG_BIAS_DEFAULT;
      end else if (chan_srst[ch]) begin
        bias[ch] <= `DCG_BIAS_DEFAULT;
      end else if (write_hit(commit, lnk.word_addr, BiasAddr)) begin
        bias[ch] <= lnk.word_data;
      end
    end

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        atten[ch] <= `DCG_ATTEN_DEFAULT;
      end else if (chan_srst[ch]) begin
        atten[ch] <= `DCG_ATTEN_DEFAULT;
      end else if (write_hit(commit, lnk.word_addr, AttenAddr)) begin
        atten[ch] <= lnk.word_data[`DCG_ATTEN_MSB:0];
      end
    end

    // Sleep only gates the analog side; contents stay as they are
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        sleep_q[ch] <= 1'h0;
        bias_q[ch] <= `DCG_BIAS_DEFAULT;
        atten_q[ch] <= {`DCG_ATTEN_RSVD, `DCG_ATTEN_DEFAULT};
      end else begin
        sleep_q[ch] <= sleep_bit[ch] | pin_sync;
        bias_q[ch] <= bias[ch];
        atten_q[ch] <= {`DCG_ATTEN_RSVD, atten[ch]};
      end
    end

    dcg_bias_step u_step (
      .clock(clock),
      .rst_n(rst_n),
      .bias(bias[ch]),
      .step(step_q[ch])
    );
  end

  // ************************************************************
  // Read mirror and outputs
  // ************************************************************
  // Mirror changes only after a committed write, which is at least an address
  // byte ahead of any read that could sample it
  assign lnk.mirror.srst = place_bits(chan_srst[0], chan_srst[1]);
  assign lnk.mirror.sleep = place_bits(sleep_bit[0], sleep_bit[1]);
  assign lnk.mirror.a_bias = bias[0];
  assign lnk.mirror.a_atten = {`DCG_ATTEN_RSVD, atten[0]};
  assign lnk.mirror.b_bias = bias[1];
  assign lnk.mirror.b_atten = {`DCG_ATTEN_RSVD, atten[1]};

  assign chan_a_sleep = sleep_q[0];
  assign chan_b_sleep = sleep_q[1];
  assign chan_a_bias_out = bias_q[0];
  assign chan_a_atten_out = atten_q[0];
  assign chan_b_bias_out = bias_q[1];
  assign chan_b_atten_out = atten_q[1];
  assign chan_a_bias_step = step_q[0];
  assign chan_b_bias_step = step_q[1];

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_srst_self_clear: assert property (chan_srst[0] |=> !chan_srst[0] [*3])
    else $error("channel A soft reset did not clear itself");
  a_srst_zero_noop: assert property (
    (write_hit(commit, lnk.word_addr, `DCG_ADDR_SRST) && !lnk.word_data[`DCG_BIT_CHAN_B]) |=> !chan_srst[1])
    else $error("writing zero started a channel B soft reset");
  a_srst_a_defaults: assert property (
    chan_srst[0] |=> bias[0] == `DCG_BIAS_DEFAULT && atten[0] == `DCG_ATTEN_DEFAULT && !sleep_bit[0])
    else $error("channel A soft reset left a register off default");
  a_srst_b_defaults: assert property (
    chan_srst[1] |=> ##1 chan_b_atten_out == {`DCG_ATTEN_RSVD, `DCG_ATTEN_DEFAULT})
    else $error("channel B soft reset left attenuator off default");
  a_srst_b_untouched: assert property (
    (chan_srst[0] && !chan_srst[1]) |=> $stable(bias[1]) && $stable(atten[1]) && $stable(sleep_bit[1]))
    else $error("channel A soft reset disturbed channel B");
  a_a_bias_output: assert property (
    write_hit(commit, lnk.word_addr, `DCG_ADDR_A_BIAS) |=> ##1 chan_a_bias_out == $past(lnk.word_data, 2))
    else $error("channel A bias output did not follow the write");
  a_a_atten_output: assert property (
    write_hit(commit, lnk.word_addr, `DCG_ADDR_A_ATTEN)
      |=> ##1 chan_a_atten_out == {`DCG_ATTEN_RSVD, $past(lnk.word_data[`DCG_ATTEN_MSB:0], 2)})
    else $error("channel A attenuator output did not follow the write");
  a_b_bias_output: assert property (
    write_hit(commit, lnk.word_addr, `DCG_ADDR_B_BIAS) |=> ##1 chan_b_bias_out == $past(lnk.word_data, 2))
    else $error("channel B bias output did not follow the write");
  a_b_atten_output: assert property (
    write_hit(commit, lnk.word_addr, `DCG_ADDR_B_ATTEN)
      |=> ##1 chan_b_atten_out == {`DCG_ATTEN_RSVD, $past(lnk.word_data[`DCG_ATTEN_MSB:0], 2)})
    else $error("channel B attenuator output did not follow the write");
  a_sleep_out_or: assert property (
    ##1 chan_a_sleep == $past(sleep_bit[0] | pin_sync) && chan_b_sleep == $past(sleep_bit[1] | pin_sync))
    else $error("sleep output disagrees with bit and pin");
  a_sleep_keeps_regs: assert property (
    (pin_sync && !commit && !chan_srst[0]) |=> $stable(bias[0]) && $stable(atten[0]))
    else $error("sleep changed channel A contents");
  a_rsvd_write_ignored: assert property (
    (commit && (lnk.word_addr < `DCG_ADDR_SRST || lnk.word_addr > `DCG_ADDR_LAST))
      |=> !chan_srst[0] && !chan_srst[1] && $stable(bias[0]) && $stable(bias[1])
          && $stable(atten[0]) && $stable(atten[1]) && $stable(sleep_bit[0]) && $stable(sleep_bit[1]))
    else $error("write to read-only address changed state");
  a_rsvd_bits_zero: assert property (
    (lnk.mirror.srst & 8'hEE) == 8'h00 && (lnk.mirror.sleep & 8'hEE) == 8'h00)
    else $error("reserved control bit reads one");
  a_atten_top_zero: assert property (
    chan_a_atten_out[7:6] == `DCG_ATTEN_RSVD && chan_b_atten_out[7:6] == `DCG_ATTEN_RSVD)
    else $error("attenuator reserved bits not zero");

  c_soft_reset_a: cover property (chan_srst[0]);
  c_write_atten_b: cover property (write_hit(commit, lnk.word_addr, `DCG_ADDR_B_ATTEN));
  c_pin_sleep: cover property ($rose(pin_sync) ##2 chan_a_sleep && chan_b_sleep);
  c_both_reset: cover property (chan_srst[0] && chan_srst[1]);

  // Write strobes of the control registers
  logic hit_srst;
  logic hit_sleep;
  assign hit_srst = write_hit(commit, lnk.word_addr, `DCG_ADDR_SRST);
  assign hit_sleep = write_hit(commit, lnk.word_addr, `DCG_ADDR_SLEEP);

  // Commit crosses as a toggle, so one edge gives one pulse
  a_commit_single: assert property (commit |=> !commit)
    else $error("commit lasted more than one cycle");

  a_srst_b_clear: assert property (chan_srst[1] |=> !chan_srst[1] [*3])
    else $error("channel B soft reset did not clear itself");

  a_srst_a_start: assert property (
    (hit_srst && lnk.word_data[`DCG_BIT_CHAN_A]) |=> chan_srst[0])
    else $error("writing one did not reset channel A");

  a_srst_b_start: assert property (
    (hit_srst && lnk.word_data[`DCG_BIT_CHAN_B]) |=> chan_srst[1])
    else $error("writing one did not reset channel B");

  a_srst_a_noop: assert property (
    (hit_srst && !lnk.word_data[`DCG_BIT_CHAN_A]) |=> !chan_srst[0])
    else $error("writing zero reset channel A");

  a_srst_b_regs: assert property (
    chan_srst[1] |=> bias[1] == `DCG_BIAS_DEFAULT && atten[1] == `DCG_ATTEN_DEFAULT && !sleep_bit[1])
    else $error("channel B soft reset left a register off default");

  a_srst_a_untouched: assert property (
    (chan_srst[1] && !chan_srst[0]) |=> $stable(bias[0]) && $stable(atten[0]) && $stable(sleep_bit[0]))
    else $error("channel B soft reset disturbed channel A");

  // Outputs trail the registers by the output flop
  a_srst_a_outputs: assert property (
    chan_srst[0] |=> ##1 chan_a_bias_out == `DCG_BIAS_DEFAULT
      && chan_a_atten_out == {`DCG_ATTEN_RSVD, `DCG_ATTEN_DEFAULT})
    else $error("channel A soft reset left an output off default");

  a_srst_b_outputs: assert property (
    chan_srst[1] |=> ##1 chan_b_bias_out == `DCG_BIAS_DEFAULT
      && chan_b_atten_out == {`DCG_ATTEN_RSVD, `DCG_ATTEN_DEFAULT})
    else $error("channel B soft reset left an output off default");

  // A soft reset in the same cycle takes priority over the write
  a_sleep_a_write: assert property (
    (hit_sleep && !chan_srst[0]) |=> sleep_bit[0] == $past(lnk.word_data[`DCG_BIT_CHAN_A]))
    else $error("channel A sleep bit did not take the write");

  a_sleep_b_write: assert property (
    (hit_sleep && !chan_srst[1]) |=> sleep_bit[1] == $past(lnk.word_data[`DCG_BIT_CHAN_B]))
    else $error("channel B sleep bit did not take the write");

  // The pin alone is enough to sleep both channels
  a_pin_sleeps_all: assert property (pin_sync |=> chan_a_sleep && chan_b_sleep)
    else $error("sleep pin did not put both channels to sleep");

  // Sleep gates only the analog side
  a_sleep_keeps_b: assert property (
    (pin_sync && !commit && !chan_srst[1]) |=> $stable(bias[1]) && $stable(atten[1]))
    else $error("sleep changed channel B contents");

  // Registers move only by a commit or a soft reset
  a_a_regs_hold: assert property (
    (!commit && !chan_srst[0]) |=> $stable(bias[0]) && $stable(atten[0]) && $stable(sleep_bit[0]))
    else $error("channel A register changed on its own");

  a_b_regs_hold: assert property (
    (!commit && !chan_srst[1]) |=> $stable(bias[1]) && $stable(atten[1]) && $stable(sleep_bit[1]))
    else $error("channel B register changed on its own");

  c_sleep_write: cover property (hit_sleep);
endmodule
`default_nettype wire

// *** bench/dcg_spi_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Serial host model
// ************************************************************
module dcg_spi_host (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo_line
);
  localparam int HALF = 24;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Shifts n bits MSB first; rd keeps the data byte of the last word
  // Clock stands low outside frames, as a real host leaves it
  task automatic frame(input logic [31:0] bits, input int n, output logic [7:0] rd);
    int p;
    rd = 8'h00;
    cs_n = 1'b0;
    for (int k = 0; k < n; k++) begin
      p = k % 16;
      sdi = bits[n-1-k];
      #HALF sclk = 1'b1;
      if (p >= 8) begin
        rd[15-p] = sdo_line;
      end
      #HALF sclk = 1'b0;
    end
    #HALF cs_n = 1'b1;
    // Released line must not keep looking valid
    sdi = ~sdi;
    #(2 * HALF);
  endtask
endmodule
`default_nettype wire

// *** bench/dcg_regs_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dcg_defines.svh"
module dcg_regs_top_tb;
  logic clock;
  logic rst_n;
  logic sleep_pin;
  logic spi_sclk;
  logic spi_cs_n;
  logic spi_sdi;
  logic spi_sdo;
  logic spi_sdo_oe;
  logic sdo_held;
  logic sdo_line;
  logic chan_a_sleep;
  logic chan_b_sleep;
  dcg_pkg::dcg_byte_t chan_a_bias_out;
  dcg_pkg::dcg_byte_t chan_a_atten_out;
  dcg_pkg::dcg_byte_t chan_b_bias_out;
  dcg_pkg::dcg_byte_t chan_b_atten_out;
  dcg_pkg::dcg_step_t chan_a_bias_step;
  dcg_pkg::dcg_step_t chan_b_bias_step;
  dcg_pkg::dcg_byte_t rd;
  dcg_pkg::dcg_byte_t dflt [8];
  int errors;
  int checks;
  int cycles;
  // ************************************************************
  // Design, host and wire
  // ************************************************************
  dcg_regs_top dut (.clock(clock), .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .sleep_pin(sleep_pin),
    .chan_a_sleep(chan_a_sleep), .chan_b_sleep(chan_b_sleep), .chan_a_bias_out(chan_a_bias_out),
    .chan_a_atten_out(chan_a_atten_out), .chan_b_bias_out(chan_b_bias_out),
    .chan_b_atten_out(chan_b_atten_out), .chan_a_bias_step(chan_a_bias_step),
    .chan_b_bias_step(chan_b_bias_step));
  dcg_spi_host host (.sclk(spi_sclk), .cs_n(spi_cs_n), .sdi(spi_sdi), .sdo_line(sdo_line));
  // Undriven line shows the inverse of its last value, so a late enable shows up
  always @(spi_sdo or spi_sdo_oe) begin
    if (spi_sdo_oe) begin
      sdo_held = spi_sdo;
    end
  end
  assign sdo_line = spi_sdo_oe ? spi_sdo : ~sdo_held;
  always #20 clock = ~clock;
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk_byte(input string name, input dcg_pkg::dcg_byte_t exp, input dcg_pkg::dcg_byte_t got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_step(input string name, input dcg_pkg::dcg_step_t exp, input dcg_pkg::dcg_step_t got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_bit(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask
  // Leaves room for the two-flop crossing, register and output flop
  task automatic xfer(input logic [31:0] bits, input int n);
    host.frame(bits, n, rd);
    repeat (6) @(posedge clock);
  endtask
  task automatic wr(input dcg_pkg::dcg_addr_t a, input dcg_pkg::dcg_byte_t d);
    xfer({16'h0000, 1'b0, a, d}, 16);
  endtask
  // Reads send all ones as data, which the device must ignore
  task automatic chk_reg(input dcg_pkg::dcg_addr_t a, input dcg_pkg::dcg_byte_t exp);
    xfer({16'h0000, 1'b1, a, 8'hFF}, 16);
    chk_byte($sformatf("reg %0h", a), exp, rd);
  endtask
  task automatic chk_outs(input dcg_pkg::dcg_byte_t ab, input dcg_pkg::dcg_byte_t aa,
                          input dcg_pkg::dcg_byte_t bb, input dcg_pkg::dcg_byte_t ba);
    chk_byte("chan_a_bias_out", ab, chan_a_bias_out);
    chk_byte("chan_a_atten_out", aa, chan_a_atten_out);
    chk_byte("chan_b_bias_out", bb, chan_b_bias_out);
    chk_byte("chan_b_atten_out", ba, chan_b_atten_out);
  endtask
  task automatic chk_defaults();
    for (int a = 0; a < 8; a++) begin
      chk_reg(7'(a), dflt[a]);
    end
    chk_outs(8'h20, 8'h14, 8'h20, 8'h14);
    chk_step("chan_a_bias_step", 4'h6, chan_a_bias_step);
    chk_step("chan_b_bias_step", 4'h6, chan_b_bias_step);
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    sleep_pin = 1'b0;
    errors = 0;
    checks = 0;
    cycles = 0;
    sdo_held = 1'b0;
    dflt = '{`DCG_REV_CODE, `DCG_PART_CODE, 8'h00, 8'h00, 8'h20, 8'h14, 8'h20, 8'h14};
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    chk_defaults();
    chk_bit("chan_a_sleep", 1'b0, chan_a_sleep);
    $display("test reset_defaults done");
    wr(7'h04, 8'h81);
    wr(7'h05, 8'hE7);
    wr(7'h06, 8'h00);
    wr(7'h07, 8'h3F);
    chk_reg(7'h04, 8'h81);
    chk_reg(7'h05, 8'h27);
    chk_reg(7'h06, 8'h00);
    chk_reg(7'h07, 8'h3F);
    chk_outs(8'h81, 8'h27, 8'h00, 8'h3F);
    chk_step("chan_a_bias_step", 4'h8, chan_a_bias_step);
    // Lower bits set too: only the top set bit may count
    for (int k = 0; k < 9; k++) begin
      wr(7'h06, 8'hFF >> (8 - k));
      chk_step("chan_b_bias_step", 4'(k), chan_b_bias_step);
    end
    wr(7'h05, 8'hC0);
    chk_reg(7'h05, 8'h00);
    $display("test data_registers done");
    wr(7'h03, 8'hFF);
    chk_reg(7'h03, 8'h11);
    chk_bit("chan_a_sleep", 1'b1, chan_a_sleep);
    chk_bit("chan_b_sleep", 1'b1, chan_b_sleep);
    wr(7'h02, 8'hEE);
    chk_reg(7'h02, 8'h00);
    chk_reg(7'h04, 8'h81);
    wr(7'h00, 8'hFF);
    wr(7'h01, 8'h00);
    wr(7'h08, 8'hFF);
    wr(7'h7F, 8'hFF);
    chk_reg(7'h00, `DCG_REV_CODE);
    chk_reg(7'h01, `DCG_PART_CODE);
    chk_reg(7'h08, 8'h00);
    chk_reg(7'h40, 8'h00);
    chk_reg(7'h7F, 8'h00);
    wr(7'h03, 8'h00);
    @(posedge clock);
    sleep_pin <= 1'b1;
    repeat (4) @(posedge clock);
    chk_bit("chan_b_sleep", 1'b1, chan_b_sleep);
    chk_reg(7'h07, 8'h3F);
    sleep_pin <= 1'b0;
    $display("test reserved_and_sleep done");
    wr(7'h05, 8'h27);
    wr(7'h06, 8'h40);
    wr(7'h07, 8'h01);
    wr(7'h03, 8'h11);
    wr(7'h02, 8'h00);
    chk_reg(7'h04, 8'h81);
    wr(7'h02, 8'h01);
    chk_reg(7'h02, 8'h00);
    chk_reg(7'h04, 8'h20);
    chk_reg(7'h05, 8'h14);
    chk_reg(7'h06, 8'h40);
    chk_reg(7'h07, 8'h01);
    chk_reg(7'h03, 8'h10);
    wr(7'h02, 8'h10);
    chk_reg(7'h06, 8'h20);
    chk_reg(7'h07, 8'h14);
    chk_outs(8'h20, 8'h14, 8'h20, 8'h14);
    $display("test soft_reset done");
    xfer({20'h00000, 12'h045}, 12);
    chk_reg(7'h04, 8'h20);
    xfer({12'h000, 16'h0455, 4'hA}, 20);
    chk_reg(7'h04, 8'h55);
    xfer({16'h0521, 16'h0677}, 32);
    chk_reg(7'h05, 8'h21);
    chk_reg(7'h06, 8'h77);
    xfer({16'h85FF, 16'h86FF}, 32);
    chk_byte("streamed read", 8'h77, rd);
    $display("test framing done");
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    chk_defaults();
    $display("test second_reset done");
    close_out();
  end
endmodule
`default_nettype wire
